/* passthrough_pkg.sv */
// Constants, types and register map of the wired-to-contactless buffer handover.
// Assumes one system clock; the contactless link clock is sampled as data.
//
// Operation
// R1: While the wired side owns the buffer, a completed wired write to the terminator page sets the ready flag.
// R2: That same terminator write clears wired ownership and returns the arbiter to idle.
// R3: From idle with the ready flag set, the arbiter grants the buffer to the contactless side.
// R4: A contactless read whose page range covers the terminator page clears the ready flag and contactless ownership.
// R5: The wired host writes new buffer data only after the contactless side has read the terminator page.
// R6: The contactless reader polls the ready flag in the session status register to learn of new data.
// R7: When the detect-pin selector fields at config bits 5:2 ask for it, the detect pin signals a finished read.
// R8: Addressing the device on the wired bus grants wired ownership when the arbiter is idle and the ready flag is clear.
// R9: The handshake works only while pass-through is enabled; the buffer then spans 16 pages.
// R10: The terminator page defaults to the last of the 16 pages and is configurable.
package passthrough_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 8;
  localparam int PAGE_W     = 4;
  localparam int IRQ_W      = 4;
  localparam int LINK_IN_W  = 11;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFFS_CONFIG      = 8'h00;
  localparam logic [ADDR_W-1:0] OFFS_TERM_PAGE   = 8'h01;
  localparam logic [ADDR_W-1:0] OFFS_STATUS      = 8'h02;
  localparam logic [ADDR_W-1:0] OFFS_IRQ_STATUS  = 8'h03;
  localparam logic [ADDR_W-1:0] OFFS_IRQ_MASK    = 8'h04;
  localparam logic [ADDR_W-1:0] OFFS_HANDOVERS   = 8'h05;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_PASSTHROUGH_BIT  = 0;
  localparam int CFG_ASSERT_SEL_LSB   = 2;
  localparam int CFG_RELEASE_SEL_LSB  = 4;
  localparam int ST_WIRED_BIT         = 0;
  localparam int ST_CONTACTLESS_BIT   = 1;
  localparam int ST_READY_BIT         = 2;
  localparam int ST_PIN_LEVEL_BIT     = 3;
  localparam int IRQ_READY_BIT        = 0;
  localparam int IRQ_CONSUMED_BIT     = 1;
  localparam int IRQ_REFUSED_BIT      = 2;
  localparam int IRQ_STRAY_READ_BIT   = 3;

  // ----------------------------------------------------------------------
  // Values and reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK   = 8'h3F;
  localparam logic [DATA_W-1:0] CFG_RESET        = 8'h00;
  localparam logic [PAGE_W-1:0] TERM_PAGE_RESET  = 4'hF;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RESET   = 4'h0;
  localparam logic [1:0]        DETECT_SEL_PASS  = 2'h3;
  localparam logic [DATA_W-1:0] HANDOVER_STEP    = 8'h01;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_WIRED,
    ARB_CONTACTLESS
  } arb_e;

  typedef struct packed {
    logic [PAGE_W-1:0] first_page;
    logic [PAGE_W-1:0] last_page;
  } rf_read_s;

  typedef struct packed {
    logic              link_clk;
    logic              valid;
    rf_read_s          pages;
    logic              pin_level;
  } link_in_s;

  typedef struct packed {
    logic              addressed;
    logic              write_done;
    logic [PAGE_W-1:0] write_page;
  } wired_evt_s;

endpackage : passthrough_pkg

/* input_sync.sv */
// Three-stage synchroniser for a vector of asynchronous inputs.
// A new level is taken once stages two and three agree.
`timescale 1ns/1ps
module input_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] stable
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } sync_s;

  sync_s q;
  sync_s next_q;

  // ----------------------------------------------------------------------
  // Per-bit filter
  // ----------------------------------------------------------------------
  always_comb begin
    next_q    = q;
    next_q.s1 = raw;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.filt[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign stable = q.filt;

endmodule : input_sync

/* detect_pin_drive.sv */
// Open-drain detect pin: pulled low after a contactless read, let go on release.
// Assumes one-cycle event pulses on the system clock.
`timescale 1ns/1ps
module detect_pin_drive (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Control
  input  wire logic       enable,
  input  wire logic [1:0] assert_sel,
  input  wire logic [1:0] release_sel,
  input  wire logic       consumed,
  input  wire logic       release_evt,
  // Pin
  output logic            pin_o,
  output logic            pin_oe
);

  typedef struct packed {
    logic pin_o;
    logic pin_oe;
  } pin_s;

  pin_s q;
  pin_s next_q;

  // ----------------------------------------------------------------------
  // Assert wins over release
  // ----------------------------------------------------------------------
  always_comb begin
    next_q       = q;
    next_q.pin_o = 1'b0;
    if (!enable) begin
      next_q.pin_oe = 1'b0;
    end else if (consumed && assert_sel == passthrough_pkg::DETECT_SEL_PASS) begin
      next_q.pin_oe = 1'b1; // R7
    end else if (release_evt && release_sel == passthrough_pkg::DETECT_SEL_PASS) begin
      next_q.pin_oe = 1'b0; // R7
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign pin_o  = q.pin_o;
  assign pin_oe = q.pin_oe;

endmodule : detect_pin_drive

/* sram_passthrough_wired_to_rf.sv */
// Buffer ownership arbiter for the wired-to-contactless pass-through direction.
// Wired events come from logic on REF_CLK; the contactless link and pin are asynchronous.
`timescale 1ns/1ps
module sram_passthrough_wired_to_rf (
  // Clock, reset, enable
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Wired side events
  input  wire logic       WIRED_ADDRESSED,
  input  wire logic       WIRED_WRITE_DONE,
  input  wire logic [3:0] WIRED_WRITE_PAGE,
  // Contactless read link
  input  wire logic       RF_LINK_CLK,
  input  wire logic       RF_LINK_VALID,
  input  wire logic [3:0] RF_LINK_FIRST,
  input  wire logic [3:0] RF_LINK_LAST,
  // Field detect pin
  input  wire logic       FIELD_DETECT_PIN_I,
  output logic            FIELD_DETECT_PIN_O,
  output logic            FIELD_DETECT_PIN_OE,
  // Status and interrupt
  output logic            IRQ,
  output logic            WIRED_OWNS,
  output logic            CONTACTLESS_OWNS,
  output logic            BUFFER_READY
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    passthrough_pkg::arb_e                           arb;
    logic                                            ready;
    logic [passthrough_pkg::DATA_W-1:0]              cfg;
    logic [passthrough_pkg::PAGE_W-1:0]              term_page;
    logic [passthrough_pkg::IRQ_W-1:0]               irq_status;
    logic [passthrough_pkg::IRQ_W-1:0]               irq_mask;
    logic [passthrough_pkg::DATA_W-1:0]              handovers;
    logic [passthrough_pkg::DATA_W-1:0]              rdata;
    logic                                            irq;
    logic                                            link_clk_prev;
    logic                                            wired_owns;
    logic                                            contactless_owns;
  } arb_state_s;

  localparam arb_state_s RESET_STATE = '{
    arb:              passthrough_pkg::ARB_IDLE,
    ready:            1'b0,
    cfg:              passthrough_pkg::CFG_RESET,
    term_page:        passthrough_pkg::TERM_PAGE_RESET,
    irq_status:       '0,
    irq_mask:         passthrough_pkg::IRQ_MASK_RESET,
    handovers:        '0,
    rdata:            '0,
    irq:              1'b0,
    link_clk_prev:    1'b0,
    wired_owns:       1'b0,
    contactless_owns: 1'b0
  };

  arb_state_s q;
  arb_state_s next_q;

  // ----------------------------------------------------------------------
  // Input gathering and synchronisation
  // ----------------------------------------------------------------------
  passthrough_pkg::link_in_s   link_raw;
  passthrough_pkg::link_in_s   link_sync;
  passthrough_pkg::wired_evt_s wired;

  assign link_raw.link_clk         = RF_LINK_CLK;
  assign link_raw.valid            = RF_LINK_VALID;
  assign link_raw.pages.first_page = RF_LINK_FIRST;
  assign link_raw.pages.last_page  = RF_LINK_LAST;
  assign link_raw.pin_level        = FIELD_DETECT_PIN_I;

  assign wired.addressed  = WIRED_ADDRESSED;
  assign wired.write_done = WIRED_WRITE_DONE;
  assign wired.write_page = WIRED_WRITE_PAGE;

  input_sync #(
    .W (passthrough_pkg::LINK_IN_W)
  ) u_link_sync (
    .clk    (REF_CLK),
    .rst_b  (RST_B),
    .ce     (CE),
    .raw    (link_raw),
    .stable (link_sync)
  );

  // ----------------------------------------------------------------------
  // Decoded control fields
  // ----------------------------------------------------------------------
  logic       pt_en;
  logic [1:0] assert_sel;
  logic [1:0] release_sel;

  assign pt_en       = q.cfg[passthrough_pkg::CFG_PASSTHROUGH_BIT];
  assign assert_sel  = q.cfg[passthrough_pkg::CFG_ASSERT_SEL_LSB +: 2];
  assign release_sel = q.cfg[passthrough_pkg::CFG_RELEASE_SEL_LSB +: 2];

  // ----------------------------------------------------------------------
  // Contactless read decode
  // ----------------------------------------------------------------------
  logic link_rise;
  logic rf_read;
  logic covers_term;

  // Read range may wrap past the last page
  always_comb begin
    link_rise = link_sync.link_clk && !q.link_clk_prev;
    rf_read   = link_rise && link_sync.valid;
    if (link_sync.pages.first_page <= link_sync.pages.last_page) begin
      covers_term = (link_sync.pages.first_page <= q.term_page) &&
                    (q.term_page <= link_sync.pages.last_page);
    end else begin
      covers_term = (link_sync.pages.first_page <= q.term_page) ||
                    (q.term_page <= link_sync.pages.last_page);
    end
  end

  // ----------------------------------------------------------------------
  // Wired write decode
  // ----------------------------------------------------------------------
  logic term_write;

  assign term_write = wired.write_done && (wired.write_page == q.term_page); // R10

  // ----------------------------------------------------------------------
  // Arbiter, registers, interrupt
  // ----------------------------------------------------------------------
  logic [passthrough_pkg::IRQ_W-1:0] irq_events;
  logic                              ev_consumed;
  logic                              ev_release;
  logic                              irq_clear;
  logic [passthrough_pkg::DATA_W-1:0] status_word;

  always_comb begin
    next_q      = q;
    irq_events  = '0;
    ev_consumed = 1'b0;
    ev_release  = 1'b0;
    next_q.link_clk_prev = link_sync.link_clk;

    case (q.arb)
      passthrough_pkg::ARB_IDLE: begin
        if (pt_en && q.ready) begin
          next_q.arb       = passthrough_pkg::ARB_CONTACTLESS; // R3
          next_q.handovers = q.handovers + passthrough_pkg::HANDOVER_STEP;
        end else if (pt_en && wired.addressed) begin
          next_q.arb = passthrough_pkg::ARB_WIRED; // R8
          ev_release = 1'b1;
        end
        if (rf_read && covers_term) begin
          irq_events[passthrough_pkg::IRQ_STRAY_READ_BIT] = 1'b1;
        end
      end
      passthrough_pkg::ARB_WIRED: begin
        if (term_write) begin
          next_q.ready = 1'b1;                     // R1
          next_q.arb   = passthrough_pkg::ARB_IDLE; // R2
          irq_events[passthrough_pkg::IRQ_READY_BIT] = 1'b1;
        end
        if (rf_read && covers_term) begin
          irq_events[passthrough_pkg::IRQ_STRAY_READ_BIT] = 1'b1;
        end
      end
      passthrough_pkg::ARB_CONTACTLESS: begin
        if (rf_read && covers_term) begin
          next_q.ready = 1'b0;                     // R4
          next_q.arb   = passthrough_pkg::ARB_IDLE; // R4
          ev_consumed  = 1'b1;
          irq_events[passthrough_pkg::IRQ_CONSUMED_BIT] = 1'b1;
        end
        // Wired writes here break the handshake and are only flagged
        if (wired.write_done) begin
          irq_events[passthrough_pkg::IRQ_REFUSED_BIT] = 1'b1; // R5
        end
      end
      default: begin
        next_q.arb = passthrough_pkg::ARB_IDLE;
      end
    endcase

    if (!pt_en) begin
      next_q.arb   = passthrough_pkg::ARB_IDLE; // R9
      next_q.ready = 1'b0;                      // R9
    end

    // Register writes
    if (WR) begin
      case (ADDR)
        passthrough_pkg::OFFS_CONFIG: begin
          next_q.cfg = WDATA & passthrough_pkg::CFG_WRITE_MASK;
        end
        passthrough_pkg::OFFS_TERM_PAGE: begin
          next_q.term_page = WDATA[passthrough_pkg::PAGE_W-1:0]; // R10
        end
        passthrough_pkg::OFFS_IRQ_MASK: begin
          next_q.irq_mask = WDATA[passthrough_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid one cycle later only
    status_word = '0;
    status_word[passthrough_pkg::ST_WIRED_BIT]       = q.wired_owns;
    status_word[passthrough_pkg::ST_CONTACTLESS_BIT] = q.contactless_owns;
    status_word[passthrough_pkg::ST_READY_BIT]       = q.ready; // R6
    status_word[passthrough_pkg::ST_PIN_LEVEL_BIT]   = link_sync.pin_level;
    irq_clear    = 1'b0;
    next_q.rdata = '0;
    if (RD) begin
      case (ADDR)
        passthrough_pkg::OFFS_CONFIG: begin
          next_q.rdata = q.cfg;
        end
        passthrough_pkg::OFFS_TERM_PAGE: begin
          next_q.rdata = {{(passthrough_pkg::DATA_W-passthrough_pkg::PAGE_W){1'b0}}, q.term_page};
        end
        passthrough_pkg::OFFS_STATUS: begin
          next_q.rdata = status_word;
        end
        passthrough_pkg::OFFS_IRQ_STATUS: begin
          next_q.rdata = {{(passthrough_pkg::DATA_W-passthrough_pkg::IRQ_W){1'b0}}, q.irq_status};
          irq_clear    = 1'b1;
        end
        passthrough_pkg::OFFS_IRQ_MASK: begin
          next_q.rdata = {{(passthrough_pkg::DATA_W-passthrough_pkg::IRQ_W){1'b0}}, q.irq_mask};
        end
        passthrough_pkg::OFFS_HANDOVERS: begin
          next_q.rdata = q.handovers;
        end
        default: begin
          next_q.rdata = '0;
        end
      endcase
    end

    // Sticky events; a new event beats the read-clear
    next_q.irq_status = (irq_clear ? '0 : q.irq_status) | irq_events;
    next_q.irq        = |(next_q.irq_status & next_q.irq_mask);

    next_q.wired_owns       = (next_q.arb == passthrough_pkg::ARB_WIRED);
    next_q.contactless_owns = (next_q.arb == passthrough_pkg::ARB_CONTACTLESS);
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= RESET_STATE;
    end else if (CE) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Field detect pin
  // ----------------------------------------------------------------------
  detect_pin_drive u_detect (
    .clk         (REF_CLK),
    .rst_b       (RST_B),
    .ce          (CE),
    .enable      (pt_en),
    .assert_sel  (assert_sel),
    .release_sel (release_sel),
    .consumed    (ev_consumed),
    .release_evt (ev_release),
    .pin_o       (FIELD_DETECT_PIN_O),
    .pin_oe      (FIELD_DETECT_PIN_OE)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RDATA            = q.rdata;
  assign IRQ              = q.irq;
  assign WIRED_OWNS       = q.wired_owns;
  assign CONTACTLESS_OWNS = q.contactless_owns;
  assign BUFFER_READY     = q.ready;

endmodule : sram_passthrough_wired_to_rf

/* rf_reader_model.sv */
// Contactless reader model: reports one finished buffer read per link frame.
// Assumes the bench calls read_range; the link clock stands still between frames.
`timescale 1ns/1ps
module rf_reader_model (
  // Link
  output logic       link_clk,
  output logic       valid,
  output logic [3:0] first,
  output logic [3:0] last
);
  initial begin
    link_clk = 1'b0;
    valid    = 1'b0;
    first    = 4'h0;
    last     = 4'h0;
  end

  // One rising link edge, fields held 200 ns either side
  task automatic read_range(input logic [3:0] f, input logic [3:0] l);
    #13;
    valid = 1'b1;
    first = f;
    last  = l;
    #200;
    link_clk = 1'b1;
    #100;
    link_clk = 1'b0;
    #100;
    // Released lines show inverted values
    valid = 1'b0;
    first = ~f;
    last  = ~l;
  endtask : read_range
endmodule : rf_reader_model

/* passthrough_asserts.sv */
// Checker of the buffer handover arbiter, bound to its top module.
// Assumes config and terminator page change only through the register port.
`timescale 1ns/1ps
module passthrough_asserts (
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       RST_B,
  input wire logic       CE,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  // Events and outputs
  input wire logic       WIRED_ADDRESSED,
  input wire logic       WIRED_WRITE_DONE,
  input wire logic [3:0] WIRED_WRITE_PAGE,
  input wire logic       FIELD_DETECT_PIN_O,
  input wire logic       FIELD_DETECT_PIN_OE,
  input wire logic       WIRED_OWNS,
  input wire logic       CONTACTLESS_OWNS,
  input wire logic       BUFFER_READY
);
  logic       pt;
  logic [1:0] asel;
  logic [3:0] term;
  wire        cfg_wr = CE && WR && (ADDR == passthrough_pkg::OFFS_CONFIG);

  // Shadow of config and terminator page
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pt   <= 1'b0;
      asel <= 2'h0;
      term <= 4'hF;
    end else if (CE && WR) begin
      if (ADDR == passthrough_pkg::OFFS_CONFIG) begin
        pt   <= WDATA[0];
        asel <= WDATA[3:2];
      end
      if (ADDR == passthrough_pkg::OFFS_TERM_PAGE) begin
        term <= WDATA[3:0];
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_term_wr;
    CE && !cfg_wr && WIRED_OWNS && WIRED_WRITE_DONE && (WIRED_WRITE_PAGE == term);
  endsequence
  sequence s_idle_ready;
    CE && pt && !cfg_wr && BUFFER_READY && !WIRED_OWNS && !CONTACTLESS_OWNS;
  endsequence

  property p_ready_set;   s_term_wr |=> BUFFER_READY; endproperty
  property p_wired_clear; s_term_wr |=> !WIRED_OWNS && !CONTACTLESS_OWNS; endproperty
  property p_grant;       s_idle_ready |=> CONTACTLESS_OWNS && BUFFER_READY; endproperty
  property p_release;     $fell(CONTACTLESS_OWNS) && pt |-> !BUFFER_READY && !WIRED_OWNS; endproperty
  property p_pin_assert;
    $fell(CONTACTLESS_OWNS) && $past(pt) && ($past(asel) == 2'h3) |-> FIELD_DETECT_PIN_OE;
  endproperty
  property p_pin_od;      FIELD_DETECT_PIN_OE |-> !FIELD_DETECT_PIN_O; endproperty
  property p_owner;
    CE && pt && !cfg_wr && WIRED_ADDRESSED && !WIRED_OWNS && !CONTACTLESS_OWNS && !BUFFER_READY |=> WIRED_OWNS;
  endproperty
  property p_disabled;    CE && !pt && !cfg_wr |=> !WIRED_OWNS && !CONTACTLESS_OWNS && !BUFFER_READY; endproperty
  property p_pin_off;     CE && !pt && !cfg_wr |=> !FIELD_DETECT_PIN_OE; endproperty
  property p_nonterm;
    CE && pt && !cfg_wr && WIRED_OWNS && WIRED_WRITE_DONE && (WIRED_WRITE_PAGE != term)
      |=> WIRED_OWNS && !BUFFER_READY;
  endproperty

  a_ready_set:   assert property (p_ready_set)   else $error("ready flag not set");
  a_wired_clear: assert property (p_wired_clear) else $error("wired ownership kept");
  a_grant:       assert property (p_grant)       else $error("no contactless grant");
  a_release:     assert property (p_release)     else $error("ready kept after read");
  a_pin_assert:  assert property (p_pin_assert)  else $error("detect pin not asserted");
  a_pin_od:      assert property (p_pin_od)      else $error("detect pin driven high");
  a_owner:       assert property (p_owner)       else $error("no wired grant");
  a_disabled:    assert property (p_disabled)    else $error("owned while disabled");
  a_pin_off:     assert property (p_pin_off)     else $error("pin held while disabled");
  a_nonterm:     assert property (p_nonterm)     else $error("non-terminator handover");
endmodule : passthrough_asserts

bind sram_passthrough_wired_to_rf passthrough_asserts u_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .WIRED_ADDRESSED(WIRED_ADDRESSED), .WIRED_WRITE_DONE(WIRED_WRITE_DONE),
  .WIRED_WRITE_PAGE(WIRED_WRITE_PAGE), .FIELD_DETECT_PIN_O(FIELD_DETECT_PIN_O),
  .FIELD_DETECT_PIN_OE(FIELD_DETECT_PIN_OE), .WIRED_OWNS(WIRED_OWNS),
  .CONTACTLESS_OWNS(CONTACTLESS_OWNS), .BUFFER_READY(BUFFER_READY)
);

/* sram_passthrough_wired_to_rf_tb_top.sv */
// Self-checking bench of the wired-to-contactless buffer handover.
// Assumes the reader model file and the bound checker are compiled first.
`timescale 1ns/1ps
module sram_passthrough_wired_to_rf_tb_top;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic       wr = 1'b0, rd = 1'b0, w_addr = 1'b0, w_done = 1'b0;
  logic [3:0] w_page = 4'h0, lf, ll, f, l;
  logic       lclk, lval, irq, fo, foe, own_w, own_c, rdy;
  wire        pin_wire = foe ? fo : 1'b1;
  int         errors = 0, total_checks = 0, cycles = 0;
  int         mw = 0, mc = 0, mr = 0, mf = 0, mirq = 0, mmask = 0, mcnt = 0, mt = 15;

  always #12.5 clk = ~clk;

  rf_reader_model rf (.link_clk(lclk), .valid(lval), .first(lf), .last(ll));

  sram_passthrough_wired_to_rf dut (
    .REF_CLK(clk), .RST_B(rst_b), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .WIRED_ADDRESSED(w_addr), .WIRED_WRITE_DONE(w_done), .WIRED_WRITE_PAGE(w_page),
    .RF_LINK_CLK(lclk), .RF_LINK_VALID(lval), .RF_LINK_FIRST(lf), .RF_LINK_LAST(ll),
    .FIELD_DETECT_PIN_I(pin_wire), .FIELD_DETECT_PIN_O(fo), .FIELD_DETECT_PIN_OE(foe), .IRQ(irq),
    .WIRED_OWNS(own_w), .CONTACTLESS_OWNS(own_c), .BUFFER_READY(rdy)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic ports();
    chk({3'h0, irq, foe, rdy, own_c, own_w}, {3'h0, |(mirq & mmask), mf[0], mr[0], mc[0], mw[0]});
  endtask : ports

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0; wdata <= ~v;
    #1;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg

  task automatic evt(input logic a, input logic dn, input logic [3:0] p);
    @(posedge clk);
    w_addr <= a; w_done <= dn; w_page <= p;
    @(posedge clk);
    w_addr <= 1'b0; w_done <= 1'b0; w_page <= ~p;
    #1;
  endtask : evt

  task automatic status();
    rreg(passthrough_pkg::OFFS_STATUS, d);
    chk(d, {4'h0, ~mf[0], mr[0], mc[0], mw[0]});
  endtask : status

  task automatic irqs();
    rreg(passthrough_pkg::OFFS_IRQ_STATUS, d);
    chk(d, mirq[7:0]);
    mirq = 0;
  endtask : irqs

  task automatic handover();
    evt(1'b0, 1'b1, mt[3:0]);
    mr = 1; mw = 0; mirq |= 1;
    ports();
    @(posedge clk);
    #1 mc = 1;
    mcnt++;
    ports();
  endtask : handover

  function automatic bit covers(input logic [3:0] a, input logic [3:0] b);
    return (a <= b) ? (mt >= a && mt <= b) : (mt >= a || mt <= b);
  endfunction : covers

  task automatic rfread(input logic [3:0] a, input logic [3:0] b);
    rf.read_range(a, b);
    if (covers(a, b)) begin
      if (mc != 0) begin
        mc = 0; mr = 0; mf = 1; mirq |= 2;
      end else mirq |= 8;
    end
    @(posedge clk);
    #1 ports();
  endtask : rfread

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h480d3e62));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rreg(passthrough_pkg::OFFS_CONFIG, d); chk(d, 8'h00);
    rreg(passthrough_pkg::OFFS_TERM_PAGE, d); chk(d, 8'h0F);
    rreg(passthrough_pkg::OFFS_IRQ_MASK, d); chk(d, 8'h00);
    rreg(8'h07, d); chk(d, 8'h00);
    status();
    evt(1'b1, 1'b0, 4'h0); ports();
    wreg(passthrough_pkg::OFFS_CONFIG, 8'h3D);
    wreg(passthrough_pkg::OFFS_IRQ_MASK, 8'h03);
    mmask = 3;
    rreg(passthrough_pkg::OFFS_CONFIG, d); chk(d, 8'h3D);
    evt(1'b1, 1'b0, 4'h0); mw = 1; ports();
    evt(1'b0, 1'b1, 4'($urandom_range(0, 14))); ports();
    handover();
    status();
    irqs();
    ports();
    // Host writes new data before the reader has taken the terminator page; the write is flagged as refused
    evt(1'b0, 1'b1, 4'h3); mirq |= 4; ports();
    evt(1'b1, 1'b0, 4'h0); ports();
    f = 4'($urandom_range(0, 14));
    l = 4'($urandom_range(f, 14));
    rfread(f, l);
    rfread(4'hE, 4'h1);
    repeat (4) @(posedge clk);
    status();
    irqs();
    for (int i = 0; i < 4; i++) begin
      rfread(4'($urandom_range(0, 15)), 4'($urandom_range(0, 15)));
    end
    irqs();
    evt(1'b1, 1'b0, 4'h0); mw = 1; mf = 0; ports();
    wreg(passthrough_pkg::OFFS_TERM_PAGE, 8'h05); mt = 5;
    evt(1'b0, 1'b1, 4'hF); ports();
    handover();
    rreg(passthrough_pkg::OFFS_HANDOVERS, d); chk(d, mcnt[7:0]);
    // Clock enable low: the config write must be ignored
    @(posedge clk);
    ce <= 1'b0;
    wreg(passthrough_pkg::OFFS_CONFIG, 8'h00);
    ce <= 1'b1;
    ports();
    rreg(passthrough_pkg::OFFS_CONFIG, d); chk(d, 8'h3D);
    wreg(passthrough_pkg::OFFS_CONFIG, 8'h00); mc = 0; mr = 0; mf = 0;
    @(posedge clk);
    #1 ports();
    final_report();
  end
endmodule : sram_passthrough_wired_to_rf_tb_top
